/* File: rtl/mrs_cfg.svh */
// constants for the motor drive run sequencer
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

`define MRS_CLK_PERIOD_NS   40
`define MRS_TICK_PERIOD_NS  1000000
`define MRS_TICK_CYCLES     (`MRS_TICK_PERIOD_NS / `MRS_CLK_PERIOD_NS)

`define MRS_WORD_RESET      16'h0000
`define MRS_BIT_ENABLE      0
`define MRS_BIT_START       1
`define MRS_BIT_JOG         2
`define MRS_BIT_JOG_SEL     3
`define MRS_BIT_ACK         8
`define MRS_BIT_RTRIP_N     9
`define MRS_BIT_VALID       15
`define MRS_ACK_MASK        16'h030f
`define MRS_ACK_WORD        16'h0300

`define MRS_PIN_FREE_WHEEL  0
`define MRS_PIN_FAST_STOP   1
`define MRS_PIN_RUN_REQ     2
`define MRS_PIN_PERMIT      3
`define MRS_PIN_INCH        4
`define MRS_PIN_COUNT       5

`endif

/* File: rtl/mrs_pkg.sv */
// types shared by the run sequencer modules
package mrs_pkg;

    typedef enum logic [4:0] {
        MRS_IDLE  = 5'b00001,
        MRS_RUN   = 5'b00010,
        MRS_NSTOP = 5'b00100,
        MRS_PSTOP = 5'b01000,
        MRS_HOLD  = 5'b10000
    } mrs_state_e;

    typedef enum logic [2:0] {
        MRS_SP_NONE   = 3'h0,
        MRS_SP_PLAIN  = 3'h1,
        MRS_SP_JOG1   = 3'h2,
        MRS_SP_JOG2   = 3'h3,
        MRS_SP_CRAWL  = 3'h4,
        MRS_SP_SLACK1 = 3'h5,
        MRS_SP_SLACK2 = 3'h6
    } mrs_setpoint_e;

    typedef enum logic [1:0] {
        MRS_RAMP_NONE   = 2'h0,
        MRS_RAMP_NORMAL = 2'h1,
        MRS_RAMP_FAST   = 2'h2
    } mrs_ramp_e;

endpackage : mrs_pkg

/* File: rtl/mrs_timer_if.sv */
// link between the sequencer and one of its period timers
interface mrs_timer_if;
    logic        run;
    logic        tick;
    logic [15:0] period;
    logic        expired;

    modport ctrl  (output run, output tick, output period, input expired);
    modport timer (input run, input tick, input period, output expired);
endinterface : mrs_timer_if

/* File: rtl/mrs_period_timer.sv */
// millisecond period timer, cleared whenever run is low
module mrs_period_timer
    import mrs_pkg::*;
(
    input  wire logic   clock_in,
    input  wire logic   rst_n_in,
    mrs_timer_if.timer  tmr
);

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        expired_reg;
    logic        expired_next;

    always_comb begin
        count_next   = count_reg;
        expired_next = 1'b0;
        if (!tmr.run) begin
            count_next = 16'h0000;
        end else begin
            if (tmr.tick && (count_reg < tmr.period)) begin
                count_next = count_reg + 16'h0001;
            end
            expired_next = (count_next >= tmr.period);
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg   <= 16'h0000;
            expired_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign tmr.expired = expired_reg;

endmodule : mrs_period_timer

/* File: rtl/mrs_sequencer.sv */
// motor drive run sequencer: stops, trips, starts, jog, crawl, slack, remote word
`include "mrs_cfg.svh"

module mrs_sequencer
    import mrs_pkg::*;
#(
    parameter int TICK_CYCLES = `MRS_TICK_CYCLES
)
(
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        FREE_WHEEL_STOP_IN,
    input  wire logic        FAST_STOP_IN,
    input  wire logic        RUN_REQUEST_IN,
    input  wire logic        DRIVE_PERMIT_IN,
    input  wire logic        INCH_REQUEST_IN,
    input  wire logic        INCH_MODE_IN,
    input  wire logic        REMOTE_CONTROL_SELECT_IN,
    input  wire logic        TRIP_IN,
    input  wire logic        ALARM_RESET_IN,
    input  wire logic        ZERO_SPEED_IN,
    input  wire logic [15:0] NORMAL_STOP_PERIOD_IN,
    input  wire logic [15:0] FAST_DECEL_PERIOD_IN,
    input  wire logic [15:0] CONTACTOR_DELAY_IN,
    input  wire logic        REM_WORD_WR_IN,
    input  wire logic [15:0] REM_WORD_DATA_IN,
    output logic      [15:0] REM_WORD_OUT,
    output logic             REM_WORD_REJECT_OUT,
    output logic             STACK_ENABLE_OUT,
    output logic             CONTACTOR_OUT,
    output logic      [2:0]  SETPOINT_SEL_OUT,
    output logic      [1:0]  STOP_RAMP_OUT,
    output logic             ALARM_OUT,
    output logic             HEALTHY_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and millisecond tick

    logic [`MRS_PIN_COUNT-1:0] pin_raw;
    logic [`MRS_PIN_COUNT-1:0] sync1_reg;
    logic [`MRS_PIN_COUNT-1:0] sync2_reg;
    logic [15:0]               tick_cnt_reg;
    logic [15:0]               tick_cnt_next;
    logic                      tick_reg;
    logic                      tick_next;

    assign pin_raw = {INCH_REQUEST_IN, DRIVE_PERMIT_IN, RUN_REQUEST_IN, FAST_STOP_IN, FREE_WHEEL_STOP_IN};

    always_comb begin
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        tick_next     = 1'b0;
        if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_next = 16'h0000;
            tick_next     = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else begin
            sync1_reg    <= pin_raw;
            sync2_reg    <= sync1_reg;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remote word and alarm

    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic        reject_reg;
    logic        reject_next;
    logic        alarm_reg;
    logic        alarm_next;
    logic        trip_cond;
    logic        ack_req;

    always_comb begin
        word_next   = word_reg;
        reject_next = 1'b0;
        if (REM_WORD_WR_IN) begin
            if (!REM_WORD_DATA_IN[`MRS_BIT_VALID]) begin
                word_next = REM_WORD_DATA_IN;
            end else begin
                reject_next = 1'b1;
            end
        end
    end

    always_comb begin
        trip_cond = TRIP_IN || (REMOTE_CONTROL_SELECT_IN && !word_reg[`MRS_BIT_RTRIP_N]);
        ack_req = ALARM_RESET_IN ||
                  (REMOTE_CONTROL_SELECT_IN && ((word_reg & `MRS_ACK_MASK) == `MRS_ACK_WORD));
        alarm_next = alarm_reg;
        // set wins over acknowledge
        if (trip_cond) begin
            alarm_next = 1'b1;
        end else if (ack_req) begin
            alarm_next = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            word_reg   <= `MRS_WORD_RESET;
            reject_reg <= 1'b0;
            alarm_reg  <= 1'b0;
        end else begin
            word_reg   <= word_next;
            reject_reg <= reject_next;
            alarm_reg  <= alarm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective commands

    logic coast_dem;
    logic fast_dem;
    logic permit;
    logic start_req;
    logic jog_req;
    logic inch_sel;
    logic start_ok;

    always_comb begin
        coast_dem = !sync2_reg[`MRS_PIN_FREE_WHEEL];
        fast_dem  = !sync2_reg[`MRS_PIN_FAST_STOP];
        if (REMOTE_CONTROL_SELECT_IN) begin
            permit    = word_reg[`MRS_BIT_ENABLE];
            start_req = word_reg[`MRS_BIT_START];
            jog_req   = word_reg[`MRS_BIT_JOG];
            inch_sel  = word_reg[`MRS_BIT_JOG_SEL];
        end else begin
            permit    = sync2_reg[`MRS_PIN_PERMIT];
            start_req = sync2_reg[`MRS_PIN_RUN_REQ];
            jog_req   = sync2_reg[`MRS_PIN_INCH];
            inch_sel  = INCH_MODE_IN;
        end
        // start interlocks
        // a trip in this very cycle must not pulse the contactor
        start_ok = (start_req || jog_req) && !alarm_reg && !trip_cond && !coast_dem && !fast_dem;
    end

    ////////////////////////////////////////////////////////////////////////
    // period timers

    mrs_timer_if nstop_if ();
    mrs_timer_if pstop_if ();
    mrs_timer_if hold_if ();

    mrs_state_e state_reg;
    mrs_state_e state_next;

    assign nstop_if.run    = (state_reg == MRS_NSTOP);
    assign nstop_if.tick   = tick_reg;
    assign nstop_if.period = NORMAL_STOP_PERIOD_IN;
    assign pstop_if.run    = (state_reg == MRS_PSTOP);
    assign pstop_if.tick   = tick_reg;
    assign pstop_if.period = FAST_DECEL_PERIOD_IN;
    assign hold_if.run     = (state_reg == MRS_HOLD);
    assign hold_if.tick    = tick_reg;
    assign hold_if.period  = CONTACTOR_DELAY_IN;

    mrs_period_timer u_nstop (.clock_in(CLOCK_IN), .rst_n_in(RST_N_IN), .tmr(nstop_if.timer));
    mrs_period_timer u_pstop (.clock_in(CLOCK_IN), .rst_n_in(RST_N_IN), .tmr(pstop_if.timer));
    mrs_period_timer u_hold  (.clock_in(CLOCK_IN), .rst_n_in(RST_N_IN), .tmr(hold_if.timer));

    ////////////////////////////////////////////////////////////////////////
    // run state machine and outputs

    logic [2:0] sp_next;
    logic [2:0] sp_reg;
    logic [1:0] ramp_next;
    logic [1:0] ramp_reg;
    logic       stack_next;
    logic       stack_reg;
    logic       cont_next;
    logic       cont_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MRS_IDLE: begin
                if (start_ok) begin
                    state_next = MRS_RUN;
                end
            end
            MRS_RUN: begin
                if (coast_dem || trip_cond) begin
                    state_next = MRS_IDLE;
                end else if (fast_dem) begin
                    state_next = MRS_PSTOP;
                end else if (!start_req && !jog_req) begin
                    state_next = MRS_NSTOP;
                end
            end
            MRS_NSTOP: begin
                if (coast_dem || trip_cond || nstop_if.expired) begin
                    state_next = MRS_IDLE;
                end else if (fast_dem) begin
                    state_next = MRS_PSTOP;
                end else if (start_ok) begin
                    state_next = MRS_RUN;
                end else if (ZERO_SPEED_IN) begin
                    state_next = MRS_HOLD;
                end
            end
            MRS_PSTOP: begin
                // fast stop runs to zero once begun
                if (coast_dem || trip_cond || pstop_if.expired) begin
                    state_next = MRS_IDLE;
                end else if (ZERO_SPEED_IN) begin
                    state_next = MRS_HOLD;
                end
            end
            MRS_HOLD: begin
                if (coast_dem || trip_cond || hold_if.expired) begin
                    state_next = MRS_IDLE;
                end else if (start_ok) begin
                    state_next = MRS_RUN;
                end
            end
            default: begin
                state_next = MRS_IDLE;
            end
        endcase
    end

    always_comb begin
        sp_next   = MRS_SP_NONE;
        ramp_next = MRS_RAMP_NONE;
        // coast: stack off outside run, normal and fast stop; contactor off only in idle
        // trip forces idle, alarm blocks restart
        cont_next = (state_next != MRS_IDLE);
        stack_next = permit && !alarm_next &&
                     (state_next == MRS_RUN || state_next == MRS_NSTOP || state_next == MRS_PSTOP);
        if (state_next == MRS_RUN) begin
            if (start_req && jog_req && inch_sel) begin
                sp_next = MRS_SP_CRAWL;
            end else if (start_req && jog_req) begin
                sp_next = MRS_SP_SLACK1;
            end else if (start_req && inch_sel) begin
                sp_next = MRS_SP_SLACK2;
            end else if (start_req) begin
                sp_next = MRS_SP_PLAIN;
            end else begin
                sp_next = inch_sel ? MRS_SP_JOG2 : MRS_SP_JOG1;
            end
        end else if (state_next == MRS_NSTOP) begin
            ramp_next = MRS_RAMP_NORMAL;
        end else if (state_next == MRS_PSTOP) begin
            ramp_next = MRS_RAMP_FAST;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= MRS_IDLE;
            sp_reg    <= MRS_SP_NONE;
            ramp_reg  <= MRS_RAMP_NONE;
            stack_reg <= 1'b0;
            cont_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            sp_reg    <= sp_next;
            ramp_reg  <= ramp_next;
            stack_reg <= stack_next;
            cont_reg  <= cont_next;
        end
    end

    assign REM_WORD_OUT        = word_reg;
    assign REM_WORD_REJECT_OUT = reject_reg;
    assign STACK_ENABLE_OUT    = stack_reg;
    assign CONTACTOR_OUT       = cont_reg;
    assign SETPOINT_SEL_OUT    = sp_reg;
    assign STOP_RAMP_OUT       = ramp_reg;
    assign ALARM_OUT           = alarm_reg;
    assign HEALTHY_OUT         = !alarm_reg;

endmodule : mrs_sequencer

/* File: testbench/mrs_sequencer_sva.sv */
// port assertions for the run sequencer
module mrs_sequencer_chk
    import mrs_pkg::*;
(
    input wire logic        CLOCK_IN,
    input wire logic        RST_N_IN,
    input wire logic        FREE_WHEEL_STOP_IN,
    input wire logic        FAST_STOP_IN,
    input wire logic        REMOTE_CONTROL_SELECT_IN,
    input wire logic        TRIP_IN,
    input wire logic        REM_WORD_WR_IN,
    input wire logic [15:0] REM_WORD_DATA_IN,
    input wire logic [15:0] REM_WORD_OUT,
    input wire logic        REM_WORD_REJECT_OUT,
    input wire logic        STACK_ENABLE_OUT,
    input wire logic        CONTACTOR_OUT,
    input wire logic [2:0]  SETPOINT_SEL_OUT,
    input wire logic [1:0]  STOP_RAMP_OUT,
    input wire logic        ALARM_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////////////////////////////
    // two settled cycles: first may still show the old setpoint
    sequence s_slack2;
        REMOTE_CONTROL_SELECT_IN && REM_WORD_OUT == 16'h020b && STOP_RAMP_OUT == MRS_RAMP_NONE && STACK_ENABLE_OUT;
    endsequence
    sequence s_coast;
        !FREE_WHEEL_STOP_IN [*3];
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_REJECT_KEEPS: assert property (
        REM_WORD_WR_IN && REM_WORD_DATA_IN[15] |=> REM_WORD_REJECT_OUT && $stable(REM_WORD_OUT))
        else $error("rejected word changed the store");
    AST_ACCEPT_STORES: assert property (
        REM_WORD_WR_IN && !REM_WORD_DATA_IN[15] |=> !REM_WORD_REJECT_OUT && REM_WORD_OUT == $past(REM_WORD_DATA_IN))
        else $error("accepted word not stored");
    AST_COAST_OFF: assert property (
        s_coast |=> !STACK_ENABLE_OUT && !CONTACTOR_OUT)
        else $error("coast stop left stack or contactor on");
    AST_ALARM_HOLDS_OFF: assert property (
        ALARM_OUT [*2] |-> !STACK_ENABLE_OUT && !CONTACTOR_OUT)
        else $error("stack on while alarm latched");
    AST_REMOTE_TRIP: assert property (
        REMOTE_CONTROL_SELECT_IN && !REM_WORD_OUT[9] |=> ALARM_OUT)
        else $error("remote trip bit low did not raise alarm");
    AST_LOCAL_TRIP: assert property (
        TRIP_IN |=> ALARM_OUT)
        else $error("trip did not raise alarm");
    AST_REMOTE_ACK: assert property (
        REMOTE_CONTROL_SELECT_IN && (REM_WORD_OUT & 16'h030f) == 16'h0300 && !TRIP_IN && ALARM_OUT
        |=> !ALARM_OUT)
        else $error("ack pattern did not clear alarm");
    AST_NSTOP_NO_SP: assert property (
        STOP_RAMP_OUT == MRS_RAMP_NORMAL |-> SETPOINT_SEL_OUT == MRS_SP_NONE)
        else $error("setpoint kept during normal stop");
    AST_FAST_BEATS_NORMAL: assert property (
        !FAST_STOP_IN [*3] |=> STOP_RAMP_OUT != MRS_RAMP_NORMAL)
        else $error("normal ramp while program stop held");
    AST_SLACK2_SP: assert property (
        s_slack2 ##1 s_slack2 |-> SETPOINT_SEL_OUT == MRS_SP_SLACK2)
        else $error("slack two setpoint missing");
endmodule : mrs_sequencer_chk

bind mrs_sequencer mrs_sequencer_chk mrs_sequencer_chk_i (.CLOCK_IN, .RST_N_IN, .FREE_WHEEL_STOP_IN, .FAST_STOP_IN,
    .REMOTE_CONTROL_SELECT_IN, .TRIP_IN, .REM_WORD_WR_IN, .REM_WORD_DATA_IN, .REM_WORD_OUT, .REM_WORD_REJECT_OUT,
    .STACK_ENABLE_OUT, .CONTACTOR_OUT, .SETPOINT_SEL_OUT, .STOP_RAMP_OUT, .ALARM_OUT);

/* File: testbench/mrs_field_master.sv */
// terminal and field bus master model driving the sequencer
module mrs_field_master (
    input  wire logic        clock_in,
    output logic             fw_out,
    output logic             fs_out,
    output logic             run_out,
    output logic             permit_out,
    output logic             wr_out,
    output logic      [15:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {fw_out, fs_out, run_out, permit_out, wr_out} = 5'h18;
        data_out = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // reserved bits zero
    task write_word(input logic [15:0] w);
        @(negedge clock_in);
        wr_out = 1'b1;
        data_out = w & 16'h830f;
        @(negedge clock_in);
        wr_out = 1'b0;
        // idle bus shows the inverse, never a stale match
        data_out = ~data_out;
    endtask : write_word
    task set_stops(input logic fw, input logic fs);
        @(negedge clock_in);
        fw_out = fw;
        fs_out = fs;
    endtask : set_stops
    task local_start;
        @(negedge clock_in);
        permit_out = 1'b1;
        @(negedge clock_in);
        run_out = 1'b1;
    endtask : local_start
    task set_levels(input logic run, input logic permit);
        @(negedge clock_in);
        run_out = run;
        permit_out = permit;
    endtask : set_levels
endmodule : mrs_field_master

/* File: testbench/mrs_sequencer_tb_top.sv */
// self-checking bench for the run sequencer
module mrs_sequencer_tb_top
    import mrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sel = 1'b1;
    logic        trip = 1'b0;
    logic        ack = 1'b0;
    logic        jog = 1'b0;
    logic        mode = 1'b0;
    logic        zspd = 1'b0;
    logic [15:0] nsp = 16'h0064;
    wire         fw, fs, run, permit, wr, reject, stack, cont, alarm, healthy;
    wire  [15:0] data, word;
    wire  [2:0]  sp;
    wire  [1:0]  ramp;
    int          comparisons = 0;
    int          miscompares = 0;
    always #20 clk = ~clk;
    mrs_field_master fm (.clock_in(clk), .fw_out(fw), .fs_out(fs), .run_out(run), .permit_out(permit),
        .wr_out(wr), .data_out(data));
    mrs_sequencer #(.TICK_CYCLES(4)) mrs_sequencer_i (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .FREE_WHEEL_STOP_IN(fw), .FAST_STOP_IN(fs),
        .RUN_REQUEST_IN(run), .DRIVE_PERMIT_IN(permit), .INCH_REQUEST_IN(jog), .INCH_MODE_IN(mode),
        .REMOTE_CONTROL_SELECT_IN(sel), .TRIP_IN(trip), .ALARM_RESET_IN(ack), .ZERO_SPEED_IN(zspd),
        .NORMAL_STOP_PERIOD_IN(nsp), .FAST_DECEL_PERIOD_IN(16'h0064), .CONTACTOR_DELAY_IN(16'h0003),
        .REM_WORD_WR_IN(wr), .REM_WORD_DATA_IN(data), .REM_WORD_OUT(word), .REM_WORD_REJECT_OUT(reject),
        .STACK_ENABLE_OUT(stack), .CONTACTOR_OUT(cont), .SETPOINT_SEL_OUT(sp), .STOP_RAMP_OUT(ramp),
        .ALARM_OUT(alarm), .HEALTHY_OUT(healthy));
    ////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task chk_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_bit
    task chk_vec(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_vec
    task tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task drive_word(input logic [15:0] w);
        fm.write_word(w);
        tick(3);
    endtask : drive_word
    ////////////////////////////////////////////////////////////////
    task t_remote;
        mrs_setpoint_e e [6];
        logic [15:0]   w [6];
        e = '{MRS_SP_JOG1, MRS_SP_JOG2, MRS_SP_CRAWL, MRS_SP_SLACK1, MRS_SP_SLACK2, MRS_SP_PLAIN};
        w = '{16'h0205, 16'h020d, 16'h020f, 16'h0207, 16'h020b, 16'h0203};
        chk_vec("word", 16'h0000, word);
        // zero reset word reads as remote trip
        chk_bit("healthy", 1'b0, healthy);
        drive_word(16'h0300);
        chk_bit("healthy", 1'b1, healthy);
        drive_word(16'h0203);
        chk_bit("stack", 1'b1, stack);
        chk_bit("contactor", 1'b1, cont);
        for (int i = 0; i < 6; i++) begin
            drive_word(w[i]);
            chk_vec("setpoint", 16'(e[i]), 16'(sp));
        end
        fm.write_word(16'h8000);
        chk_bit("reject", 1'b1, reject);
        chk_vec("word", 16'h0203, word);
        $display("done remote");
    endtask : t_remote
    task t_stops;
        int n;
        fm.set_stops(1'b1, 1'b0);
        tick(5);
        chk_vec("ramp", 16'(MRS_RAMP_FAST), 16'(ramp));
        fm.set_stops(1'b0, 1'b0);
        tick(5);
        chk_vec("ramp", 16'(MRS_RAMP_NONE), 16'(ramp));
        chk_bit("stack", 1'b0, stack);
        chk_bit("contactor", 1'b0, cont);
        drive_word(16'h0201);
        fm.set_stops(1'b1, 1'b0);
        drive_word(16'h0203);
        tick(3);
        chk_bit("contactor", 1'b0, cont);
        fm.set_stops(1'b1, 1'b1);
        nsp = 16'h0002;
        tick(5);
        drive_word(16'h0201);
        chk_vec("ramp", 16'(MRS_RAMP_NORMAL), 16'(ramp));
        chk_bit("contactor", 1'b1, cont);
        for (n = 0; n < 40 && cont !== 1'b0; n++) tick(1);
        chk_bit("contactor", 1'b0, cont);
        $display("done stops");
    endtask : t_stops
    task t_alarm;
        drive_word(16'h0003);
        chk_bit("alarm", 1'b1, alarm);
        chk_bit("healthy", 1'b0, healthy);
        drive_word(16'h0203);
        chk_bit("stack", 1'b0, stack);
        drive_word(16'h0300);
        chk_bit("healthy", 1'b1, healthy);
        drive_word(16'h0203);
        chk_bit("stack", 1'b1, stack);
        drive_word(16'h0200);
        tick(40);
        $display("done alarm");
    endtask : t_alarm
    task t_local;
        sel = 1'b0;
        drive_word(16'h0203);
        chk_bit("stack", 1'b0, stack);
        fm.local_start();
        tick(5);
        chk_bit("stack", 1'b1, stack);
        trip = 1'b1;
        tick(1);
        trip = 1'b0;
        tick(3);
        chk_bit("stack", 1'b0, stack);
        ack = 1'b1;
        tick(1);
        ack = 1'b0;
        tick(5);
        chk_bit("healthy", 1'b1, healthy);
        $display("done local");
    endtask : t_local
    task t_jog;
        zspd = 1'b1;
        fm.set_levels(1'b0, 1'b1);
        tick(5);
        chk_bit("stack", 1'b0, stack);
        chk_bit("contactor", 1'b1, cont);
        jog = 1'b1;
        tick(5);
        chk_vec("setpoint", 16'(MRS_SP_JOG1), 16'(sp));
        chk_bit("contactor", 1'b1, cont);
        jog = 1'b0;
        tick(5);
        chk_bit("contactor", 1'b1, cont);
        tick(20);
        chk_bit("contactor", 1'b0, cont);
        fm.set_levels(1'b1, 1'b0);
        tick(5);
        chk_bit("contactor", 1'b1, cont);
        chk_bit("stack", 1'b0, stack);
        fm.set_levels(1'b1, 1'b1);
        tick(5);
        chk_bit("stack", 1'b1, stack);
        mode = 1'b1;
        tick(2);
        chk_vec("setpoint", 16'(MRS_SP_SLACK2), 16'(sp));
        mode = 1'b0;
        zspd = 1'b0;
        $display("done jog");
    endtask : t_jog
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        tick(1);
        t_remote();
        t_stops();
        t_alarm();
        t_local();
        t_jog();
        tally_and_finish();
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : mrs_sequencer_tb_top
